/* inc/pit_pkg.sv */
// constants for the pwm interrupt thinning and buffered reload block
// assumes a 32-bit classic wishbone register bus and one timer clock
package pit_pkg;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned BUF_COUNT = 7;
    localparam int unsigned PHASES = 3;
    // buffered register index, byte offset is four times (index + 1)
    localparam int unsigned IDX_PERIOD = 0;
    localparam int unsigned IDX_DUTY_U = 1;
    localparam int unsigned IDX_OPTION = 4;
    localparam int unsigned IDX_ADC_A = 5;
    localparam int unsigned IDX_ADC_B = 6;
    // byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PERIOD = 8'h04;
    localparam logic [7:0] OFS_DUTY_U = 8'h08;
    localparam logic [7:0] OFS_DUTY_V = 8'h0C;
    localparam logic [7:0] OFS_DUTY_W = 8'h10;
    localparam logic [7:0] OFS_OPTION = 8'h14;
    localparam logic [7:0] OFS_ADC_A = 8'h18;
    localparam logic [7:0] OFS_ADC_B = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    // control register fields
    localparam int unsigned CTRL_RUN_BIT = 0;
    localparam int unsigned CTRL_IMM_BIT = 1;
    localparam int unsigned CTRL_THIN_XFER_BIT = 2;
    // option register fields
    localparam int unsigned OPT_COUNT_LSB = 0;
    localparam int unsigned OPT_COUNT_W = 5;
    localparam int unsigned OPT_VALLEY_EN_BIT = 5;
    localparam int unsigned OPT_CREST_EN_BIT = 6;
    localparam logic [15:0] OPT_MASK = 16'h007F;
    // status register fields
    localparam int unsigned STAT_DOWN_BIT = 16;
    localparam int unsigned STAT_ARMED_BIT = 17;
    localparam int unsigned STAT_THIN_LSB = 18;
    // reset values
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
    localparam logic [15:0] BUF_RESET = 16'h0000;
    // counter values
    localparam logic [15:0] VALLEY_VALUE = 16'h0001;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
endpackage

/* logic/pit_reload.sv */
// up/down pwm counter with crest/valley interrupt thinning and buffered
// compare reload; registers over classic wishbone, single timer clock
//
// The register offsets and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - thinning acts on crest and valley only
// - crest interrupt needs crest enable bit
// - valley interrupt needs valley enable bit
// - five-bit count masks events, next passes
// - thinned transfer only with surviving interrupt
// - plain batch transfers after duty U write
// - immediate select: writes update buffers now
// - both enables with an even count give alternating crest/valley interrupts
// - thinned mode ignores non-interrupt opportunities
// - seven registers each own working buffer
// - immediate mode ignores transfer thinning select
// - plain batch needs two settings cleared
// - duty U write arms seven-register transfer
// - other writes alone never transfer
// - plain batch opportunities are every crest, valley
// - immediate 0, thinning select 1: thinned batch
// - thinned batch thins transfers like interrupts
// - one duty match per half period
// - duty writes while counting up act after turning
// - crest forces high, valley forces low
// - valley at down 0001, crest at period
// - option write clears thinning counter
module pit_reload (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    // timer events
    output logic crestIrq,
    output logic valleyIrq,
    output logic transferStrobe,
    output logic countingDown,
    // pwm and a/d trigger compares
    output logic [2:0] pwmHighSideOut,
    output logic [15:0] adcTriggerCompareA,
    output logic [15:0] adcTriggerCompareB
);
    logic ackReg;
    logic [31:0] datReg;
    logic [2:0] ctrlReg;
    logic [15:0] swReg [pit_pkg::BUF_COUNT];
    logic [15:0] wkReg [pit_pkg::BUF_COUNT];
    logic [15:0] wkNext [pit_pkg::BUF_COUNT];
    logic [15:0] cntReg;
    logic downReg;
    logic [4:0] thinReg;
    logic armedReg;
    logic crestReg;
    logic valleyReg;
    logic xferReg;
    logic [2:0] pwmReg;
    logic [15:0] adcAReg;
    logic [15:0] adcBReg;

    // checks share this clock and reset
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // bus decode
    wire busReq = wb_cyc_i && wb_stb_i;
    wire busWr = busReq && wb_we_i && ackReg;
    wire [5:0] wordAdr = wb_adr_i[7:2];
    wire ctrlHit = wb_adr_i == pit_pkg::OFS_CTRL;
    wire statHit = wb_adr_i == pit_pkg::OFS_STATUS;
    wire [2:0] bufIdx = 3'(wordAdr - 6'h01);
    wire bufHit = wb_adr_i[1:0] == 2'h0 && wordAdr >= 6'h01
        && wordAdr <= 6'h07;
    wire [15:0] wrData = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00,
        wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};
    wire lowLanes = wb_sel_i[0] || wb_sel_i[1];
    wire ctrlWr = busWr && ctrlHit && wb_sel_i[0];
    wire bufWr = busWr && bufHit && lowLanes;
    wire optWr = bufWr && bufIdx == 3'(pit_pkg::IDX_OPTION);
    wire dutyUWr = bufWr && bufIdx == 3'(pit_pkg::IDX_DUTY_U);

    // mode decode
    wire runOn = ctrlReg[pit_pkg::CTRL_RUN_BIT];
    wire immMode = ctrlReg[pit_pkg::CTRL_IMM_BIT];
    wire thinXfer = ctrlReg[pit_pkg::CTRL_THIN_XFER_BIT];
    wire [15:0] optW = wkReg[pit_pkg::IDX_OPTION];
    wire crestEn = optW[pit_pkg::OPT_CREST_EN_BIT];
    wire valleyEn = optW[pit_pkg::OPT_VALLEY_EN_BIT];
    wire [4:0] thinLimit = optW[pit_pkg::OPT_COUNT_LSB +:
        pit_pkg::OPT_COUNT_W];

    // counter events
    // crest and valley
    wire crestEv = runOn && !downReg
        && cntReg == wkReg[pit_pkg::IDX_PERIOD];
    wire valleyEv = runOn && downReg && cntReg == pit_pkg::VALLEY_VALUE;

    wire countedEv = (crestEv && crestEn) || (valleyEv && valleyEn);
    wire survive = countedEv && thinReg == thinLimit;

    wire opportunity = thinXfer ? survive : (crestEv || valleyEv);
    wire doXfer = !immMode && armedReg && opportunity;
    wire armSet = dutyUWr && !immMode;

    // read mux
    wire [31:0] statWord = {9'h000, thinReg, armedReg, downReg, cntReg};
    wire [31:0] rdWord = ctrlHit ? {29'h0, ctrlReg}
        : statHit ? statWord
        : bufHit ? {16'h0000, swReg[bufIdx]}
        : 32'h0;

    // wishbone answer, one wait state
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ackReg <= 1'b0;
            datReg <= 32'h0;
        end
        else
        begin
            ackReg <= busReq && !ackReg;
            datReg <= rdWord;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            ctrlReg <= pit_pkg::CTRL_RESET;
        else if (ctrlWr)
            ctrlReg <= wb_dat_i[2:0];
    end

    generate
        for (genvar i = 0; i < pit_pkg::BUF_COUNT; i++)
        begin : gBuf
            localparam logic [15:0] RST = (i == pit_pkg::IDX_PERIOD)
                ? pit_pkg::PERIOD_RESET : pit_pkg::BUF_RESET;
            localparam logic [15:0] MSK = (i == pit_pkg::IDX_OPTION)
                ? pit_pkg::OPT_MASK : 16'hFFFF;
            wire hit = bufWr && bufIdx == 3'(i);
            assign wkNext[i] = (hit && immMode) ? (wrData & MSK)
                : doXfer ? swReg[i] : wkReg[i];
            always_ff @(posedge clk)
            begin
                if (reset)
                begin
                    swReg[i] <= RST;
                    wkReg[i] <= RST;
                end
                else
                begin
                    if (hit)
                        swReg[i] <= wrData & MSK;
                    wkReg[i] <= wkNext[i];
                end
            end
        end
    endgenerate

    // triangle counter: up 0..m, down m+1..1
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            cntReg <= pit_pkg::COUNT_ZERO;
            downReg <= 1'b0;
        end
        else if (!runOn)
        begin
            cntReg <= pit_pkg::COUNT_ZERO;
            downReg <= 1'b0;
        end
        else if (valleyEv)
        begin
            cntReg <= pit_pkg::COUNT_ZERO;
            downReg <= 1'b0;
        end
        else if (crestEv)
        begin
            cntReg <= cntReg + 16'h0001;
            downReg <= 1'b1;
        end
        else
            cntReg <= downReg ? cntReg - 16'h0001 : cntReg + 16'h0001;
    end

    // thinning counter and arm flag
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            thinReg <= 5'h00;
            armedReg <= 1'b0;
        end
        else
        begin
            if (optWr)
                thinReg <= 5'h00;
            else if (countedEv)
                thinReg <= survive ? 5'h00 : thinReg + 5'h01;
            // set wins over transfer clear
            armedReg <= armSet || (armedReg && !doXfer && !immMode);
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            crestReg <= 1'b0;
            valleyReg <= 1'b0;
            xferReg <= 1'b0;
        end
        else
        begin
            crestReg <= survive && crestEv;
            valleyReg <= survive && valleyEv;
            xferReg <= doXfer;
        end
    end

    // high-side pwm per phase
    generate
        for (genvar p = 0; p < pit_pkg::PHASES; p++)
        begin : gPwm
            logic [15:0] cmpReg;
            logic matchedReg;
            wire match = runOn && !matchedReg && cntReg == cmpReg;
            always_ff @(posedge clk)
            begin
                if (reset)
                begin
                    cmpReg <= pit_pkg::BUF_RESET;
                    matchedReg <= 1'b0;
                    pwmReg[p] <= 1'b0;
                end
                else
                begin
                    if (downReg || valleyEv)
                        cmpReg <= wkNext[p + 1];
                    matchedReg <= (crestEv || valleyEv) ? 1'b0
                        : (matchedReg || match);
                    if (match)
                        pwmReg[p] <= !downReg;
                    else if (crestEv)
                        pwmReg[p] <= 1'b1;
                    else if (valleyEv)
                        pwmReg[p] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            adcAReg <= pit_pkg::BUF_RESET;
            adcBReg <= pit_pkg::BUF_RESET;
        end
        else
        begin
            adcAReg <= wkNext[pit_pkg::IDX_ADC_A];
            adcBReg <= wkNext[pit_pkg::IDX_ADC_B];
        end
    end

    assign wb_ack_o = ackReg;
    assign wb_dat_o = datReg;
    assign crestIrq = crestReg;
    assign valleyIrq = valleyReg;
    assign transferStrobe = xferReg;
    assign countingDown = downReg;
    assign pwmHighSideOut = pwmReg;
    assign adcTriggerCompareA = adcAReg;
    assign adcTriggerCompareB = adcBReg;

    // checks
    chk_irq_one_pulse: assert property (
        (crestIrq || valleyIrq || transferStrobe) |=>
        !(crestIrq && $past(crestIrq)) && !(valleyIrq && $past(valleyIrq))
        && !(transferStrobe && $past(transferStrobe)))
        else $error("event pulse longer than one cycle");
    chk_crest_enable_gate: assert property (
        crestIrq |-> $past(crestEv) && $past(crestEn))
        else $error("crest interrupt without enabled crest");
    chk_valley_enable_gate: assert property (
        valleyIrq |-> $past(valleyEv) && $past(valleyEn))
        else $error("valley interrupt without enabled valley");
    chk_thin_mask_event: assert property (
        countedEv && thinReg != thinLimit |=> !crestIrq && !valleyIrq)
        else $error("masked event produced an interrupt");
    chk_option_clear: assert property (
        optWr |=> thinReg == 5'h00)
        else $error("option write did not clear thinning count");
    chk_xfer_needs_arm: assert property (
        transferStrobe |-> $past(armedReg) && !$past(immMode))
        else $error("transfer without armed duty write");
    chk_thin_xfer_irq: assert property (
        transferStrobe && $past(thinXfer) |-> crestIrq || valleyIrq)
        else $error("thinned transfer without interrupt");
    chk_valley_value: assert property (
        valleyEv |=> cntReg == pit_pkg::COUNT_ZERO && !downReg)
        else $error("valley not followed by up count from zero");
    chk_xfer_copies: assert property (
        doXfer |=> wkReg[pit_pkg::IDX_ADC_B] == $past(swReg[6]))
        else $error("transfer did not copy buffered value");
    chk_imm_write_now: assert property (
        dutyUWr && immMode |=> wkReg[1] == $past(wrData))
        else $error("immediate write not applied");
    chk_crest_forces_high: assert property (
        crestEv && !gPwm[0].match |=> pwmHighSideOut[0])
        else $error("crest did not raise phase output");
    chk_imm_no_xfer: assert property (
        immMode |=> !transferStrobe)
        else $error("transfer strobe in immediate mode");
    chk_plain_xfer_event: assert property (
        transferStrobe && !$past(thinXfer) |-> $past(crestEv || valleyEv))
        else $error("plain transfer away from crest or valley");
    chk_duty_arms: assert property (
        dutyUWr && !immMode |=> armedReg)
        else $error("duty write did not arm transfer");
    chk_option_copied: assert property (
        doXfer |=> optW == $past(swReg[pit_pkg::IDX_OPTION]))
        else $error("transfer did not copy option register");
    chk_crest_turns_down: assert property (
        crestEv |=> downReg && cntReg == $past(cntReg) + 16'h0001)
        else $error("crest not followed by down count");
    chk_up_cmp_hold: assert property (
        !downReg && !valleyEv |=> $stable(gPwm[0].cmpReg))
        else $error("compare changed while counting up");
    chk_valley_forces_low: assert property (
        valleyEv && !gPwm[0].match |=> !pwmHighSideOut[0])
        else $error("valley did not lower phase output");

    cov_transfer: cover property (transferStrobe);
    cov_crest_irq: cover property (crestIrq);
    cov_valley_irq: cover property (valleyIrq);
    cov_thinned_xfer: cover property (transferStrobe && thinXfer);
    cov_down_match: cover property (gPwm[0].match && downReg);
endmodule

`default_nettype wire

/* bench/pit_reload_test.sv */
// self-checking bench for the pwm thinning and buffered reload block
// drives the wishbone port itself and watches the timer event outputs
`timescale 1ns/1ps
`default_nettype none
module pit_reload_test;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic wbCyc = 1'h0;
    logic wbStb = 1'h0;
    logic wbWe = 1'h0;
    logic [7:0] wbAdr = 8'h00;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbDatW = 32'h0;
    logic wbAck;
    logic [31:0] wbDatR;
    logic crestIrq, valleyIrq, transferStrobe, countingDown;
    logic [2:0] pwmHighSideOut;
    logic [15:0] adcA, adcB;
    logic [31:0] rd;
    logic k1, k2;
    int failCount = 0;
    int checked = 0;
    int cycles = 0;
    int gap, n, seen;

    always #2.5 clk = ~clk;

    pit_reload i_pit_reload (
        .clk(clk), .reset(reset),
        .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW),
        .wb_ack_o(wbAck), .wb_dat_o(wbDatR),
        .crestIrq(crestIrq), .valleyIrq(valleyIrq),
        .transferStrobe(transferStrobe), .countingDown(countingDown),
        .pwmHighSideOut(pwmHighSideOut),
        .adcTriggerCompareA(adcA), .adcTriggerCompareB(adcB)
    );

    task results;
        $display("checks %0d mismatches %0d", checked, failCount);
        if (failCount == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failCount++;
            results();
        end
    end

    task check(input string name, input logic [31:0] exp,
               input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            failCount++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one classic cycle, held until ack is sampled high
    task wbCycle(input logic we, input logic [7:0] adr,
                 input logic [31:0] d);
        int w;
        w = 0;
        @(posedge clk);
        wbCyc <= 1'h1;
        wbStb <= 1'h1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= 4'hF;
        wbDatW <= d;
        do
        begin
            @(posedge clk);
            w++;
        end
        while (wbAck !== 1'h1);
        rd = wbDatR;
        wbCyc <= 1'h0;
        wbStb <= 1'h0;
        wbWe <= 1'h0;
        check("wishbone wait", 32'h2, w);
    endtask

    task waitIrq(output logic crest);
        int w;
        w = 0;
        do
        begin
            @(posedge clk);
            w++;
        end
        while (crestIrq !== 1'h1 && valleyIrq !== 1'h1 && w < 700);
        crest = crestIrq;
        if (w >= 700)
            check("irq seen", 32'h1, 32'h0);
    endtask

    task waitStrobe;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (transferStrobe !== 1'h1 && n < 700);
    endtask

    // kind: 0 alternate, 1 crest only, 2 valley only, 3 same kind
    task gapTest(input logic [15:0] opt, input int expGap, input int kind);
        wbCycle(1'h1, pit_pkg::OFS_OPTION, {16'h0, opt});
        waitIrq(k1);
        waitIrq(k1);
        gap = cycles;
        waitIrq(k2);
        gap = cycles - gap;
        check("irq gap", expGap, gap);
        check("irq kind", kind == 0 ? !k1 : kind == 1 ? 1'h1 :
              kind == 2 ? 1'h0 : k1, k2);
    endtask

    initial
    begin
        repeat (16) @(posedge clk);
        reset <= 1'h0;
        wbCycle(1'h0, pit_pkg::OFS_PERIOD, 32'h0);
        check("period reset", 32'h0000FFFF, rd);
        wbCycle(1'h0, 8'h3C, 32'h0);
        check("unmapped read", 32'h0, rd);
        check("adc a reset", 32'h0, {16'h0, adcA});
        // immediate with thinning select also set, timer stopped
        wbCycle(1'h1, pit_pkg::OFS_CTRL, 32'h6);
        wbCycle(1'h1, pit_pkg::OFS_ADC_A, 32'h0055);
        repeat (2) @(posedge clk);
        check("adc a immediate", 32'h55, {16'h0, adcA});
        wbCycle(1'h1, pit_pkg::OFS_PERIOD, 32'h8);
        wbCycle(1'h1, pit_pkg::OFS_CTRL, 32'h3);
        // half period of nine cycles for a period of eight
        gapTest(16'h0060, 9, 0);
        gapTest(16'h0061, 18, 3);
        gapTest(16'h0041, 36, 1);
        gapTest(16'h0020, 18, 2);
        gapTest(16'h007F, 288, 3);
        // duty beyond the carrier never matches: forced edges only
        wbCycle(1'h1, pit_pkg::OFS_OPTION, 32'h0060);
        wbCycle(1'h1, pit_pkg::OFS_DUTY_U, 32'h0100);
        waitIrq(k1);
        if (k1 !== 1'h1)
            waitIrq(k1);
        check("down after crest", 32'h1, countingDown);
        repeat (2) @(posedge clk);
        check("pwm after crest", 32'h1, pwmHighSideOut[0]);
        waitIrq(k1);
        check("up after valley", 32'h0, countingDown);
        repeat (2) @(posedge clk);
        check("pwm after valley", 32'h0, pwmHighSideOut[0]);
        check("pwm v w at zero", 32'h3, pwmHighSideOut[2:1]);
        // immediate duty write while counting up waits for down count
        wbCycle(1'h1, pit_pkg::OFS_DUTY_U, 32'h0006);
        repeat (2) @(posedge clk);
        check("pwm up old duty", 32'h0, pwmHighSideOut[0]);
        waitIrq(k1);
        @(posedge clk);
        check("pwm forced at crest", 32'h1, pwmHighSideOut[0]);
        repeat (3) @(posedge clk);
        check("pwm down new duty", 32'h0, pwmHighSideOut[0]);
        // plain batch: unarmed writes never transfer
        wbCycle(1'h1, pit_pkg::OFS_CTRL, 32'h1);
        wbCycle(1'h1, pit_pkg::OFS_ADC_B, 32'h0B0B);
        seen = 0;
        repeat (40)
        begin
            @(posedge clk);
            if (transferStrobe === 1'h1)
                seen++;
        end
        check("strobe unarmed", 32'h0, seen);
        check("adc b unarmed", 32'h0, {16'h0, adcB});
        wbCycle(1'h1, pit_pkg::OFS_DUTY_U, 32'h0004);
        waitStrobe();
        check("strobe in time", 32'h1, n <= 11);
        check("adc b moved", 32'h0B0B, {16'h0, adcB});
        // thinned batch: transfer only with a surviving interrupt
        wbCycle(1'h1, pit_pkg::OFS_CTRL, 32'h3);
        wbCycle(1'h1, pit_pkg::OFS_OPTION, 32'h0061);
        wbCycle(1'h1, pit_pkg::OFS_CTRL, 32'h5);
        wbCycle(1'h1, pit_pkg::OFS_ADC_A, 32'h0AAA);
        wbCycle(1'h1, pit_pkg::OFS_DUTY_U, 32'h0004);
        waitStrobe();
        check("thinned strobe in time", 32'h1, n <= 19);
        check("irq with strobe", 32'h1, crestIrq | valleyIrq);
        check("adc a moved", 32'h0AAA, {16'h0, adcA});
        @(posedge clk);
        check("strobe one cycle", 32'h0, transferStrobe);
        results();
    end
endmodule
`default_nettype wire
